// ### core/clock_generator_controller.v
// clock generator controller: registers, path select and post-dividers
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.vh"
module clock_generator_controller (
  // clock and reset
  input wire clock,
  input wire rst,
  // register port from cpu or emulation
  input wire reg_sel,
  input wire reg_write,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  // clock sources as one-cycle ticks
  input wire loop_output_clock,
  input wire external_memory_clock_input,
  // loop control
  output reg loop_reset_bit,
  output reg loop_power_down_bit,
  output reg [4:0] loop_multiplier,
  output reg [4:0] prescaler_ratio,
  // system clock enables
  output reg core_system_clock,
  output reg peripheral_bus_clock,
  output reg memory_interface_system_clock,
  output reg second_clock_output_pin
);
  reg loop_path_select;
  reg memory_clock_source_select;
  reg [15:0] stable_count;
  reg stable;
  reg div0_en;
  reg div1_en;
  reg div2_en;
  reg div3_en;
  reg [4:0] div1_ratio;
  reg [4:0] div2_ratio;
  reg [4:0] div3_ratio;
  reg prescale_tick;
  reg [4:0] prescale_count;
  wire ref_tick;
  wire d1_tick;
  wire d2_tick;
  wire d3_tick;
  wire wr;
  reg [31:0] next_rdata;

  assign wr = reg_sel & reg_write;

  // register writes; any field may change at run time
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      loop_path_select <= 1'b0;
      loop_reset_bit <= 1'b1;
      loop_power_down_bit <= 1'b0;
      memory_clock_source_select <= 1'b0;
      loop_multiplier <= `MULT_RESET;
      prescaler_ratio <= `DIV0_RESET;
      div1_ratio <= `DIV1_RESET;
      div2_ratio <= `DIV2_RESET;
      div3_ratio <= `DIV3_RESET;
      div0_en <= 1'b1;
      div1_en <= 1'b1;
      div2_en <= 1'b1;
      div3_en <= 1'b1;
    end
    else if (wr)
    begin
      case (reg_addr)
        `CSR_ADDR:
        begin
          // bit 2 and other reserved bits are not stored
          loop_path_select <= reg_wdata[`CSR_PATH_BIT];
          loop_power_down_bit <= reg_wdata[`CSR_PDN_BIT];
          loop_reset_bit <= reg_wdata[`CSR_RST_BIT];
        end
        `MULT_ADDR: loop_multiplier <= reg_wdata[4:0];
        `DIV0_ADDR:
        begin
          div0_en <= reg_wdata[`DIV_EN_BIT];
          prescaler_ratio <= reg_wdata[4:0];
        end
        `DIV1_ADDR:
        begin
          div1_en <= reg_wdata[`DIV_EN_BIT];
          div1_ratio <= reg_wdata[4:0];
        end
        `DIV2_ADDR:
        begin
          div2_en <= reg_wdata[`DIV_EN_BIT];
          div2_ratio <= reg_wdata[4:0];
        end
        `DIV3_ADDR:
        begin
          div3_en <= reg_wdata[`DIV_EN_BIT];
          div3_ratio <= reg_wdata[4:0];
        end
        `CFG_ADDR: memory_clock_source_select <= reg_wdata[`CFG_MEMSRC_BIT];
        default: ;
      endcase
    end
  end

  // input stable counter after reset
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stable_count <= 16'h0000;
      stable <= 1'b0;
    end
    else if (!stable)
    begin
      if (stable_count == `STABLE_CYCLES - 1)
        stable <= 1'b1;
      stable_count <= stable_count + 16'h0001;
    end
  end

  // prescaler on the loop path; stopped only by its enable (div0_en), power-down gates ref_tick instead
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prescale_count <= 5'h00;
      prescale_tick <= 1'b0;
    end
    else
    begin
      prescale_tick <= 1'b0;
      if (div0_en && loop_output_clock)
      begin
        if (prescale_count >= prescaler_ratio)
        begin
          prescale_count <= 5'h00;
          prescale_tick <= 1'b1;
        end
        else
          prescale_count <= prescale_count + 5'h01;
      end
    end
  end

  // bypass uses the input reference, every cycle
  // the loop path is dead while the loop is held in reset or powered down
  assign ref_tick = loop_path_select ?
    (prescale_tick & ~loop_reset_bit & ~loop_power_down_bit) : 1'b1;

  post_divider u_core (
    .clock(clock),
    .rst(rst),
    .src_tick(ref_tick),
    .enable(div1_en),
    .ratio(div1_ratio),
    .tick(d1_tick)
  );
  post_divider u_periph (
    .clock(clock),
    .rst(rst),
    .src_tick(ref_tick),
    .enable(div2_en),
    .ratio(div2_ratio),
    .tick(d2_tick)
  );
  post_divider u_mem (
    .clock(clock),
    .rst(rst),
    .src_tick(ref_tick),
    .enable(div3_en),
    .ratio(div3_ratio),
    .tick(d3_tick)
  );

  // outputs registered so every pin comes from a flip-flop
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      core_system_clock <= 1'b0;
      peripheral_bus_clock <= 1'b0;
      memory_interface_system_clock <= 1'b0;
      second_clock_output_pin <= 1'b0;
    end
    else
    begin
      core_system_clock <= d1_tick;
      peripheral_bus_clock <= d2_tick;
      second_clock_output_pin <= d2_tick;
      memory_interface_system_clock <= memory_clock_source_select ?
        external_memory_clock_input : d3_tick;
    end
  end

  always @*
  begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `CSR_ADDR:
      begin
        next_rdata[`CSR_PATH_BIT] = loop_path_select;
        next_rdata[`CSR_PDN_BIT] = loop_power_down_bit;
        next_rdata[`CSR_RST_BIT] = loop_reset_bit;
        next_rdata[`CSR_STABLE_BIT] = stable;
      end
      `MULT_ADDR: next_rdata[4:0] = loop_multiplier;
      `DIV0_ADDR: next_rdata = {16'h0000, div0_en, 10'h000, prescaler_ratio};
      `DIV1_ADDR: next_rdata = {16'h0000, div1_en, 10'h000, div1_ratio};
      `DIV2_ADDR: next_rdata = {16'h0000, div2_en, 10'h000, div2_ratio};
      `DIV3_ADDR: next_rdata = {16'h0000, div3_en, 10'h000, div3_ratio};
      `CFG_ADDR: next_rdata[`CFG_MEMSRC_BIT] = memory_clock_source_select;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data is registered: valid the cycle after reg_sel with reg_write low
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_sel && !reg_write)
      reg_rdata <= next_rdata;
  end
endmodule // clock_generator_controller
`default_nettype wire

// ### core/clock_gen_defines.vh
// constants for the clock generator controller
`ifndef CLOCK_GEN_DEFINES_VH
`define CLOCK_GEN_DEFINES_VH
`define CSR_ADDR 32'h01B7C100
`define MULT_ADDR 32'h01B7C110
`define DIV0_ADDR 32'h01B7C114
`define DIV1_ADDR 32'h01B7C118
`define DIV2_ADDR 32'h01B7C11C
`define DIV3_ADDR 32'h01B7C120
`define CFG_ADDR 32'h01B7C130
`define CSR_PATH_BIT 0
`define CSR_PDN_BIT 1
`define CSR_RST_BIT 3
`define CSR_STABLE_BIT 6
`define CFG_MEMSRC_BIT 4
`define DIV_EN_BIT 15
`define DIV_RATIO_W 5
`define MULT_RESET 5'h00
`define DIV0_RESET 5'h00
`define DIV1_RESET 5'h00
`define DIV2_RESET 5'h01
`define DIV3_RESET 5'h01
`define STABLE_TIME_NS 1000
`define CLOCK_PERIOD_NS 50
`define STABLE_CYCLES ((`STABLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define LOOP_RESET_NS 125
`define LOCK_TIME_NS 187500
`define LOOP_RESET_CYCLES ((`LOOP_RESET_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define LOCK_CYCLES (`LOCK_TIME_NS / `CLOCK_PERIOD_NS)
`endif

// ### core/post_divider.v
// one programmable post-divider producing a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none
module post_divider (
  // clock and reset
  input wire clock,
  input wire rst,
  // source rate and setting
  input wire src_tick,
  input wire enable,
  input wire [4:0] ratio,
  // divided output
  output reg tick
);
  reg [4:0] count;
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= 5'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (!enable)
        count <= 5'h00;
      else if (src_tick)
      begin
        // a new ratio applies to the running count at once, no reset needed
        if (count >= ratio)
        begin
          count <= 5'h00;
          tick <= 1'b1;
        end
        else
          count <= count + 5'h01;
      end
    end
  end
endmodule // post_divider
`default_nettype wire

// ### tb/clock_gen_monitor.sv
// assertion checker for the clock generator controller ports
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.vh"
module clock_gen_monitor (
  // clock and reset
  input wire clock,
  input wire rst,
  // register port
  input wire reg_sel,
  input wire reg_write,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  // loop control and clocks
  input wire loop_reset_bit,
  input wire loop_power_down_bit,
  input wire [4:0] loop_multiplier,
  input wire [4:0] prescaler_ratio,
  input wire peripheral_bus_clock,
  input wire second_clock_output_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire wr = reg_sel && reg_write;
  wire csr_wr = wr && reg_addr == `CSR_ADDR;
  AST_RST_BIT: assert property (csr_wr |=> loop_reset_bit == $past(reg_wdata[3]))
    else $error("loop reset bit missed a write");
  AST_PDN_BIT: assert property (csr_wr |=> loop_power_down_bit == $past(reg_wdata[1]))
    else $error("power down bit missed a write");
  AST_HOLD: assert property (!csr_wr |=> $stable(loop_power_down_bit) && $stable(loop_reset_bit))
    else $error("control bits moved without a write");
  AST_DEFAULT: assert property ($fell(rst) |-> loop_reset_bit && !loop_power_down_bit
    && loop_multiplier == 5'h00 && prescaler_ratio == 5'h00)
    else $error("wrong values after reset");
  AST_RSVD: assert property (reg_sel && !reg_write && reg_addr == `CSR_ADDR
    |=> reg_rdata[31:7] == 25'h0 && reg_rdata[5:4] == 2'h0 && !reg_rdata[2])
    else $error("reserved status bits not zero");
  AST_PIN: assert property (second_clock_output_pin == peripheral_bus_clock)
    else $error("clock pin does not follow peripheral clock");
  AST_MULT: assert property (wr && reg_addr == `MULT_ADDR
    |=> loop_multiplier == $past(reg_wdata[4:0]))
    else $error("multiplier not updated");
  AST_PRE: assert property (wr && reg_addr == `DIV0_ADDR
    |=> prescaler_ratio == $past(reg_wdata[4:0]))
    else $error("prescaler not updated");
endmodule // clock_gen_monitor
bind clock_generator_controller clock_gen_monitor i_mon (.clock, .rst, .reg_sel, .reg_write,
  .reg_addr, .reg_wdata, .reg_rdata, .loop_reset_bit, .loop_power_down_bit, .loop_multiplier,
  .prescaler_ratio, .peripheral_bus_clock, .second_clock_output_pin);
`default_nettype wire

// ### tb/clock_generator_controller_tb.sv
// self-checking testbench for the clock generator controller
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defines.vh"
module clock_generator_controller_tb;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg reg_sel = 1'b0;
  reg reg_write = 1'b0;
  reg [31:0] reg_addr = 32'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg loop_output_clock = 1'b0;
  reg external_memory_clock_input = 1'b0;
  reg lp_on = 1'b0;
  reg rd_d = 1'b0;
  reg [1:0] ec = 2'h0;
  wire [31:0] reg_rdata;
  wire loop_reset_bit, loop_power_down_bit, core_system_clock, peripheral_bus_clock;
  wire memory_interface_system_clock, second_clock_output_pin;
  wire [4:0] loop_multiplier, prescaler_ratio;
  integer fails = 0;
  integer n_checks = 0;
  integer r, m;
  logic [31:0] exp_q[$];
  clock_generator_controller i_dut (.clock, .rst, .reg_sel, .reg_write, .reg_addr, .reg_wdata,
    .reg_rdata, .loop_output_clock, .external_memory_clock_input, .loop_reset_bit,
    .loop_power_down_bit, .loop_multiplier, .prescaler_ratio, .core_system_clock,
    .peripheral_bus_clock, .memory_interface_system_clock, .second_clock_output_pin);
  always #25 clock = ~clock;
  // loop ticks every 2nd cycle once enabled, external ticks every 3rd
  always @(posedge clock)
  begin
    loop_output_clock <= lp_on & ~loop_output_clock;
    ec <= (ec == 2'h2) ? 2'h0 : ec + 2'h1;
    external_memory_clock_input <= (ec == 2'h0);
    rd_d <= reg_sel & ~reg_write;
    if (rd_d)
      check(reg_rdata, exp_q.pop_front());
  end
  task check(input [31:0] seen, input [31:0] want);
    begin
      n_checks = n_checks + 1;
      if (seen !== want)
      begin
        fails = fails + 1;
        $display("FAIL %0t seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  // an idle cycle after each access keeps the strobe from being driven twice at one edge
  task acc(input w, input [31:0] a, input [31:0] d);
    begin
      reg_sel <= 1'b1;
      reg_write <= w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_sel <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd(input [31:0] a, input [31:0] want);
    begin
      exp_q.push_back(want);
      acc(1'b0, a, 32'h0);
    end
  endtask
  task cnt(input integer which, input integer cycles, input integer want);
    integer i, n;
    begin
      n = 0;
      for (i = 0; i < cycles; i = i + 1)
      begin
        @(posedge clock);
        n = n + (which == 0 ? core_system_clock : which == 1 ? peripheral_bus_clock :
          which == 2 ? memory_interface_system_clock : second_clock_output_pin);
      end
      check(n, want);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    // the lock wait dominates; the rest of the tests take well under 2500 cycles
    repeat (`LOCK_CYCLES + 2500) @(posedge clock);
    fails = fails + 1;
    complete_run;
  end
  initial
  begin
    r = $urandom(32'h33DFED06);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`CSR_ADDR, 32'h08);
    rd(`DIV2_ADDR, 32'h8001);
    rd(`CFG_ADDR, 32'h0);
    cnt(0, 10, 10);
    cnt(3, 20, 10);
    cnt(2, 20, 10);
    repeat (20) @(posedge clock);
    rd(`CSR_ADDR, 32'h48);
    acc(1'b1, `CSR_ADDR, ($urandom & 32'hFFFFFFF0) | 32'h2);
    rd(`CSR_ADDR, 32'h42);
    r = $urandom % 4;
    acc(1'b1, `DIV2_ADDR, 32'h8000 | (2 * r + 1));
    acc(1'b1, `DIV1_ADDR, 32'h8000 | r);
    repeat (40) @(posedge clock);
    cnt(0, 6 * (r + 1), 6);
    cnt(1, 12 * (r + 1), 6);
    acc(1'b1, `DIV3_ADDR, 32'h0001);
    // the output register may still show the last tick for one cycle
    @(posedge clock);
    cnt(2, 30, 0);
    acc(1'b1, `CFG_ADDR, 32'h10);
    cnt(2, 30, 10);
    acc(1'b1, 32'h01B7C104, $urandom);
    rd(32'h01B7C104, 32'h0);
    m = $urandom;
    acc(1'b1, `MULT_ADDR, m);
    acc(1'b1, `DIV0_ADDR, 32'h8000);
    rd(`MULT_ADDR, m & 32'h1F);
    // loop start-up: reset pulse, release and lock wait, all in bypass
    acc(1'b1, `CSR_ADDR, 32'h8);
    repeat (`LOOP_RESET_CYCLES) @(posedge clock);
    acc(1'b1, `CSR_ADDR, 32'h0);
    lp_on <= 1'b1;
    repeat (`LOCK_CYCLES) @(posedge clock);
    acc(1'b1, `CSR_ADDR, 32'h1);
    repeat (40) @(posedge clock);
    cnt(0, 10 * (r + 1), 5);
    acc(1'b1, `CSR_ADDR, 32'h3);
    // a tick launched at the write edge still leaves the output register
    @(posedge clock);
    cnt(0, 30, 0);
    acc(1'b1, `CSR_ADDR, 32'h9);
    cnt(0, 30, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`CSR_ADDR, 32'h08);
    rd(`MULT_ADDR, 32'h0);
    // let the compare of the last read run before the verdict
    @(posedge clock);
    complete_run;
  end
endmodule // clock_generator_controller_tb
`default_nettype wire
